// [core/flash_ecc_pkg.sv]
// Constants for the flash error-correction status block.
// Assumes a single 100 MHz system clock and a plain register port.
// How it works
// - Single-bit read errors corrected, flags set
// - Corrected-error interrupt gated by control bit
// - Multi-bit errors raise exception, except signature
// - Field chosen by command/read and array
// - Separate program 10:9 and data 12:11 fields
// - Error address captured and readable
// - Signature errors leave capture registers unchanged
// - Command field updated at signature completion
// - Command-error interrupt when enabled and nonzero
// - Single write takes 72.187 us
// - Mass erase 17.126 ms, page 17.012 ms
// - Program page: 8 slow, 248 fast writes
// - Data row: first slow, 31 fast writes
// - Status bits 31:25 read zero
// - Data corrected counter in bits 24:22
// - Program corrected counter in bits 19:17
// - Counters clear on status read, unless a count lands in the same cycle
// - Signature field bits 16:15 encoding
// - Registers at fixed offsets from base
// - Read field codes 00/01/10/11
package flash_ecc_pkg;
    localparam logic [31:0] base_address        = 32'h4001_8000;
    localparam logic [7:0]  off_flash_status    = 8'h00;
    localparam logic [7:0]  off_command_control = 8'h04;
    localparam logic [7:0]  off_command_code    = 8'h08;
    localparam logic [7:0]  off_address_keyhole = 8'h0c;
    localparam logic [7:0]  off_data_low_word   = 8'h10;
    localparam logic [7:0]  off_data_high_word  = 8'h14;
    localparam logic [7:0]  off_block_start     = 8'h18;
    localparam logic [7:0]  off_block_end       = 8'h1c;
    localparam logic [7:0]  off_unlock_key      = 8'h20;
    localparam logic [7:0]  off_prog_protect    = 8'h28;
    localparam logic [7:0]  off_data_protect    = 8'h2c;
    localparam logic [7:0]  off_corr_disable    = 8'h30;
    localparam logic [7:0]  off_signature       = 8'h34;
    localparam logic [7:0]  off_serial_wire     = 8'h38;
    localparam logic [7:0]  off_abort_address   = 8'h40;
    localparam logic [7:0]  off_abort_enable    = 8'h48;
    localparam logic [7:0]  off_key_low         = 8'h68;
    localparam logic [7:0]  off_key_high        = 8'h6c;
    localparam logic [7:0]  off_prog_err_addr   = 8'h74;
    localparam logic [7:0]  off_data_err_addr   = 8'h78;

    localparam logic [15:0] rst_command_control = 16'h0010;
    localparam logic [31:0] rst_prog_protect    = 32'hffff_ffff;
    localparam logic [7:0]  rst_data_protect    = 8'hff;
    localparam logic [15:0] rst_serial_wire     = 16'h0001;

    // Control bits inside command_control
    localparam int bit_single_irq_enable = 0;
    localparam int bit_cmd_irq_enable    = 1;
    // Status field positions
    localparam int pos_command_field = 7;
    localparam int pos_program_field = 9;
    localparam int pos_data_field    = 11;
    localparam int pos_sign_field    = 15;
    localparam int pos_prog_counter  = 17;
    localparam int pos_data_counter  = 22;

    localparam logic [1:0] clean_read         = 2'h0;
    localparam logic [1:0] uncorrected_found  = 2'h1;
    localparam logic [1:0] single_fixed       = 2'h2;
    localparam logic [1:0] mixed_errors_found = 2'h3;

    // Command codes
    localparam logic [3:0] cmd_idle       = 4'h0;
    localparam logic [3:0] cmd_sign       = 4'h2;
    localparam logic [3:0] cmd_write      = 4'h4;
    localparam logic [3:0] cmd_page_erase = 4'h5;
    localparam logic [3:0] cmd_mass_erase = 4'h6;
    localparam logic [3:0] cmd_page_write = 4'h7;

    // Command durations
    localparam int clk_mhz          = 100;
    localparam int write_slow_ns    = 72187;
    localparam int write_fast_ns    = 49740;
    localparam int mass_erase_us    = 17126;
    localparam int page_erase_us    = 17012;
    localparam int write_slow_cyc   = (write_slow_ns * clk_mhz + 999) / 1000;
    localparam int write_fast_cyc   = (write_fast_ns * clk_mhz + 999) / 1000;
    localparam int mass_erase_cyc   = mass_erase_us * clk_mhz;
    localparam int page_erase_cyc   = page_erase_us * clk_mhz;
    localparam int prog_page_locs   = 256;
    localparam int prog_slow_writes = 8;
    localparam int data_row_locs    = 32;
    localparam int data_rows        = 2;
endpackage : flash_ecc_pkg

// [core/flash_error_field.sv]
// One per-source error field with its corrected-error counter.
// Assumes event strobes on clk_sys; clear comes from a status read.
`timescale 1ns/1ps
`default_nettype none
module flash_error_field
    import flash_ecc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       single_ev,
    input  wire logic       double_ev,
    input  wire logic       status_read,
    output logic [1:0]      field_r,
    output logic [2:0]      count_r
);
    logic [1:0] field_nxt;

    always_comb begin
        field_nxt = field_r;
        if (single_ev || double_ev) begin
            // Both kinds merge into the mixed code
            field_nxt = field_r | {single_ev, double_ev};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            field_r <= clean_read;
        end else begin
            field_r <= field_nxt;
        end
    end

    // Counts only while the field already holds single_fixed, not the mixed code
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= 3'h0;
        end else if (single_ev && field_r == single_fixed) begin
            count_r <= count_r + 3'h1;
        end else if (status_read) begin
            count_r <= 3'h0;
        end
    end
endmodule : flash_error_field
`default_nettype wire

// [core/flash_cmd_timer.sv]
// Command duration timer for write, erase and page-write sequences.
// Assumes one start pulse per command; done is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_timer
    import flash_ecc_pkg::*;
#(
    parameter int slow_cyc  = write_slow_cyc,
    parameter int fast_cyc  = write_fast_cyc,
    parameter int mass_cyc  = mass_erase_cyc,
    parameter int page_cyc  = page_erase_cyc
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       start,
    input  wire logic [3:0] command,
    input  wire logic       data_array,
    output logic            busy_r,
    output logic            done_r
);
    logic [31:0] wait_r;
    logic [8:0]  loc_r;
    logic [8:0]  loc_last_r;
    logic        page_mode_r;
    logic        data_mode_r;
    logic        slow_next;
    logic [8:0]  loc_next;

    assign loc_next  = loc_r + 9'h1;
    // Slow write opens each program page run and each data row
    assign slow_next = data_mode_r ? (loc_next[4:0] == 5'h0)
                                   : (loc_next < 9'(prog_slow_writes));

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            wait_r      <= 32'h0;
            loc_r       <= 9'h0;
            loc_last_r  <= 9'h0;
            page_mode_r <= 1'b0;
            data_mode_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start && !busy_r) begin
                busy_r      <= 1'b1;
                loc_r       <= 9'h0;
                page_mode_r <= (command == cmd_page_write);
                data_mode_r <= data_array;
                loc_last_r  <= data_array ? 9'(data_row_locs * data_rows - 1) : 9'(prog_page_locs - 1);
                unique case (command)
                    cmd_mass_erase: wait_r <= 32'(mass_cyc - 1);
                    cmd_page_erase: wait_r <= 32'(page_cyc - 1);
                    default:        wait_r <= 32'(slow_cyc - 1);
                endcase
            end else if (busy_r) begin
                if (wait_r != 32'h0) begin
                    wait_r <= wait_r - 32'h1;
                end else if (page_mode_r && loc_r != loc_last_r) begin
                    loc_r  <= loc_next;
                    wait_r <= slow_next ? 32'(slow_cyc - 1) : 32'(fast_cyc - 1);
                end else begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end
endmodule : flash_cmd_timer
`default_nettype wire

// [core/flash_ecc_status.sv]
// Error-correction status and register file of the flash controller.
// Assumes ECC decoder event strobes and the register port on clk_sys.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_ecc_status
    import flash_ecc_pkg::*;
#(
    parameter int slow_cyc = write_slow_cyc,
    parameter int fast_cyc = write_fast_cyc,
    parameter int mass_cyc = mass_erase_cyc,
    parameter int page_cyc = page_erase_cyc
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    // Program array read path
    input  wire logic        prog_read,
    input  wire logic [31:0] prog_addr,
    input  wire logic        prog_single,
    input  wire logic        prog_double,
    // Data array read path
    input  wire logic        data_read,
    input  wire logic [31:0] data_addr,
    input  wire logic        data_single,
    input  wire logic        data_double,
    // Signature command read path
    input  wire logic        sign_single,
    input  wire logic        sign_double,
    input  wire logic        sign_done,
    input  wire logic        sign_initial,
    input  wire logic [23:0] sign_value,
    // Outputs
    output logic             single_irq,
    output logic             command_irq,
    output logic             ecc_exception,
    output logic             cmd_busy,
    output logic             cmd_done
);
    logic [15:0] command_control_r;
    logic [15:0] command_code_r;
    logic [31:0] address_keyhole_r;
    logic [31:0] data_low_word_r;
    logic [31:0] data_high_word_r;
    logic [31:0] block_start_page_r;
    logic [31:0] block_end_page_r;
    logic [31:0] program_write_protect_r;
    logic [7:0]  data_write_protect_r;
    logic [31:0] data_correction_disable_r;
    logic [31:0] signature_result_r;
    logic [15:0] serial_wire_control_r;
    logic [31:0] write_abort_address_r;
    logic [15:0] abort_enable_r;
    logic [31:0] analysis_key_low_r;
    logic [31:0] analysis_key_high_r;
    logic [31:0] program_error_address_r;
    logic [31:0] data_error_address_r;
    logic [1:0]  command_error_field_r;
    logic [1:0]  cmd_acc_r;
    logic [1:0]  signature_error_field_r;
    logic [1:0]  program_read_error_field;
    logic [1:0]  data_read_error_field;
    logic [2:0]  program_corrected_counter;
    logic [2:0]  data_corrected_counter;
    logic [31:0] flash_status;
    logic [31:0] rdata_nxt;
    logic        status_read;
    logic        cmd_start;
    logic        prog_s;
    logic        prog_d;
    logic        data_s;
    logic        data_d;
    logic        data_ecc_off;

    assign status_read = reg_read && (reg_addr == off_flash_status);
    assign cmd_start   = reg_write && (reg_addr == off_command_code);

    // Corrections on data pages can be switched off per page
    assign data_ecc_off = data_correction_disable_r[data_addr[11:9]];
    assign prog_s = prog_read && prog_single;
    assign prog_d = prog_read && prog_double;
    assign data_s = data_read && data_single && !data_ecc_off;
    assign data_d = data_read && data_double;

    // Normal reads go to their own array field
    flash_error_field u_prog_field (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .single_ev   (prog_s),
        .double_ev   (prog_d),
        .status_read (status_read),
        .field_r     (program_read_error_field),
        .count_r     (program_corrected_counter)
    );

    flash_error_field u_data_field (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .single_ev   (data_s),
        .double_ev   (data_d),
        .status_read (status_read),
        .field_r     (data_read_error_field),
        .count_r     (data_corrected_counter)
    );

    flash_cmd_timer #(
        .slow_cyc (slow_cyc),
        .fast_cyc (fast_cyc),
        .mass_cyc (mass_cyc),
        .page_cyc (page_cyc)
    ) u_timer (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .start      (cmd_start),
        .command    (reg_wdata[3:0]),
        .data_array (address_keyhole_r[17]),
        .busy_r     (cmd_busy),
        .done_r     (cmd_done)
    );

    // Signature errors accumulate privately until completion
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cmd_acc_r               <= clean_read;
            command_error_field_r   <= clean_read;
            signature_error_field_r <= clean_read;
            signature_result_r      <= 32'h0;
        end else if (sign_done) begin
            cmd_acc_r             <= clean_read;
            command_error_field_r <= cmd_acc_r | {sign_single, sign_double};
            signature_result_r    <= {8'h0, sign_value};
            if (sign_initial) begin
                signature_error_field_r <= cmd_acc_r | {sign_single, sign_double};
            end
        end else begin
            cmd_acc_r <= cmd_acc_r | {sign_single, sign_double};
        end
    end

    // Latest error address per array; signature reads never touch these
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            program_error_address_r <= 32'h0;
            data_error_address_r    <= 32'h0;
        end else begin
            if (prog_s || prog_d) begin
                program_error_address_r <= prog_addr;
            end
            if (data_s || data_d) begin
                data_error_address_r <= data_addr;
            end
        end
    end

    // Registered pulses
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            single_irq    <= 1'b0;
            command_irq   <= 1'b0;
            ecc_exception <= 1'b0;
        end else begin
            single_irq    <= command_control_r[bit_single_irq_enable] && (prog_s || data_s);
            command_irq   <= command_control_r[bit_cmd_irq_enable] && sign_done
                             && ((cmd_acc_r | {sign_single, sign_double}) != clean_read);
            ecc_exception <= prog_d || data_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            command_control_r         <= rst_command_control;
            command_code_r            <= 16'h0;
            address_keyhole_r         <= 32'h0;
            data_low_word_r           <= 32'h0;
            data_high_word_r          <= 32'h0;
            block_start_page_r        <= 32'h0;
            block_end_page_r          <= 32'h0;
            program_write_protect_r   <= rst_prog_protect;
            data_write_protect_r      <= rst_data_protect;
            data_correction_disable_r <= 32'h0;
            serial_wire_control_r     <= rst_serial_wire;
            write_abort_address_r     <= 32'h0;
            abort_enable_r            <= 16'h0;
            analysis_key_low_r        <= 32'h0;
            analysis_key_high_r       <= 32'h0;
        end else if (reg_write) begin
            unique case (reg_addr)
                off_command_control: command_control_r         <= reg_wdata[15:0];
                off_command_code:    command_code_r            <= reg_wdata[15:0];
                off_address_keyhole: address_keyhole_r         <= reg_wdata;
                off_data_low_word:   data_low_word_r           <= reg_wdata;
                off_data_high_word:  data_high_word_r          <= reg_wdata;
                off_block_start:     block_start_page_r        <= reg_wdata;
                off_block_end:       block_end_page_r          <= reg_wdata;
                off_prog_protect:    program_write_protect_r   <= reg_wdata;
                off_data_protect:    data_write_protect_r      <= reg_wdata[7:0];
                off_corr_disable:    data_correction_disable_r <= reg_wdata;
                off_serial_wire:     serial_wire_control_r     <= reg_wdata[15:0];
                off_abort_enable:    abort_enable_r            <= reg_wdata[15:0];
                off_key_low:         analysis_key_low_r        <= reg_wdata;
                off_key_high:        analysis_key_high_r       <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        flash_status = 32'h0;
        flash_status[pos_command_field +: 2] = command_error_field_r;
        flash_status[pos_program_field +: 2] = program_read_error_field;
        flash_status[pos_data_field +: 2]    = data_read_error_field;
        flash_status[pos_sign_field +: 2]    = signature_error_field_r;
        flash_status[pos_prog_counter +: 3]  = program_corrected_counter;
        flash_status[pos_data_counter +: 3]  = data_corrected_counter;
        flash_status[2]                      = cmd_busy;
    end

    // Unmapped and write-only addresses read zero
    always_comb begin
        unique case (reg_addr)
            off_flash_status:    rdata_nxt = flash_status;
            off_command_control: rdata_nxt = {16'h0, command_control_r};
            off_command_code:    rdata_nxt = {16'h0, command_code_r};
            off_address_keyhole: rdata_nxt = address_keyhole_r;
            off_data_low_word:   rdata_nxt = data_low_word_r;
            off_data_high_word:  rdata_nxt = data_high_word_r;
            off_block_start:     rdata_nxt = block_start_page_r;
            off_block_end:       rdata_nxt = block_end_page_r;
            off_prog_protect:    rdata_nxt = program_write_protect_r;
            off_data_protect:    rdata_nxt = {24'h0, data_write_protect_r};
            off_corr_disable:    rdata_nxt = data_correction_disable_r;
            off_signature:       rdata_nxt = signature_result_r;
            off_serial_wire:     rdata_nxt = {16'h0, serial_wire_control_r};
            off_abort_address:   rdata_nxt = write_abort_address_r;
            off_abort_enable:    rdata_nxt = {16'h0, abort_enable_r};
            off_key_low:         rdata_nxt = analysis_key_low_r;
            off_key_high:        rdata_nxt = analysis_key_high_r;
            off_prog_err_addr:   rdata_nxt = program_error_address_r;
            off_data_err_addr:   rdata_nxt = data_error_address_r;
            default:             rdata_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_read) begin
            reg_rdata <= rdata_nxt;
        end
    end
endmodule : flash_ecc_status
`default_nettype wire

// [testbench/flash_ecc_status_monitor.sv]
// Checker for the flash error-correction status block.
// Assumes binding to the top module's ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module flash_ecc_status_monitor
    import flash_ecc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        prog_read,
    input wire logic        prog_single,
    input wire logic        prog_double,
    input wire logic        data_read,
    input wire logic        data_single,
    input wire logic        data_double,
    input wire logic        sign_double,
    input wire logic        sign_done,
    input wire logic        single_irq,
    input wire logic        command_irq,
    input wire logic        ecc_exception
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire logic st_rd = reg_read && reg_addr == off_flash_status;
    wire logic no_rd = !prog_read && !data_read;
    wire logic hard  = (prog_read && prog_double) || (data_read && data_double);
    property p_exception; hard |=> ecc_exception; endproperty
    a_exception: assert property (p_exception) else $error("no exception");
    property p_sign_quiet; sign_double && !hard |=> !ecc_exception; endproperty
    a_sign_quiet: assert property (p_sign_quiet) else $error("sign exception");
    property p_single_cause; single_irq |-> $past(prog_read && prog_single) || $past(data_read && data_single); endproperty
    a_single_cause: assert property (p_single_cause) else $error("stray single irq");
    property p_cmd_irq_cause; command_irq |-> $past(sign_done); endproperty
    a_cmd_irq_cause: assert property (p_cmd_irq_cause) else $error("stray command irq");
    property p_reserved; st_rd |=> reg_rdata[31:25] == 7'h0; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits");
    property p_prog_field; prog_read && prog_single ##[1:2] st_rd |=> reg_rdata[10]; endproperty
    a_prog_field: assert property (p_prog_field) else $error("program field");
    property p_data_field; data_read && data_single ##[1:2] st_rd |=> reg_rdata[12]; endproperty
    a_data_field: assert property (p_data_field) else $error("data field");
    property p_cmd_field; sign_double ##1 sign_done ##1 !sign_done ##1 st_rd |=> reg_rdata[7]; endproperty
    a_cmd_field: assert property (p_cmd_field) else $error("command field");
    property p_cnt_clear; (st_rd && no_rd) ##1 no_rd ##1 st_rd |=> reg_rdata[24:22] == 3'h0 && reg_rdata[19:17] == 3'h0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counters kept");
endmodule : flash_ecc_status_monitor
bind flash_ecc_status flash_ecc_status_monitor u_mon (.*);
`default_nettype wire

// [testbench/flash_read_source.sv]
// Read-source model: ECC outcomes of array and signature reads.
// Assumes one call at a time from the bench's main sequence.
`timescale 1ns/1ps
`default_nettype none
module flash_read_source (
    input  wire logic   clk_sys,
    output logic        prog_read,
    output logic [31:0] prog_addr,
    output logic        prog_single,
    output logic        prog_double,
    output logic        data_read,
    output logic [31:0] data_addr,
    output logic        data_single,
    output logic        data_double,
    output logic        sign_single,
    output logic        sign_double,
    output logic        sign_done,
    output logic        sign_initial,
    output logic [23:0] sign_value
);
    initial begin
        {prog_read, prog_single, prog_double, data_read, data_single, data_double} = '0;
        {sign_single, sign_double, sign_done, sign_initial, prog_addr, data_addr, sign_value} = '0;
    end
    // Address inverted after the strobe, so a stale value never passes
    task automatic read_ev(input bit dat, input logic [31:0] a, input logic s, input logic d);
        @(posedge clk_sys);
        if (dat) {data_read, data_addr, data_single, data_double} <= {1'b1, a, s, d};
        else {prog_read, prog_addr, prog_single, prog_double} <= {1'b1, a, s, d};
        @(posedge clk_sys);
        if (dat) {data_read, data_addr, data_single, data_double} <= {1'b0, ~a, 2'b00};
        else {prog_read, prog_addr, prog_single, prog_double} <= {1'b0, ~a, 2'b00};
    endtask : read_ev
    task automatic sign_ev(input logic s, input logic d, input logic init);
        @(posedge clk_sys);
        {sign_single, sign_double} <= {s, d};
        @(posedge clk_sys);
        {sign_single, sign_double, sign_done, sign_initial, sign_value} <= {3'b001, init, 24'h5a5a5a};
        @(posedge clk_sys);
        {sign_done, sign_initial, sign_value} <= {1'b0, ~init, 24'ha5a5a5};
    endtask : sign_ev
endmodule : flash_read_source
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the flash error-correction status block.
// Assumes the read-source model beside it and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
    import flash_ecc_pkg::*;
    logic        clk_sys = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, rd_d = 1'b0;
    logic [7:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, seed = 32'h0a1e, v, la, we, wm;
    logic        prog_read, prog_single, prog_double, data_read, data_single, data_double;
    logic        sign_single, sign_double, sign_done, sign_initial;
    logic        single_irq, command_irq, ecc_exception, cmd_busy, cmd_done;
    logic [31:0] prog_addr, data_addr, exp_q[$], msk_q[$];
    logic [23:0] sign_value;
    int          checks = 0, mismatches = 0, n;
    localparam logic [31:0] sm = 32'hffff_9f80;
    logic [7:0]  offs[12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h28, 8'h2c, 8'h34, 8'h38, 8'h74, 8'h78, 8'h50};
    logic [31:0] rstv[12] = '{0, 32'h10, 0, 0, 0, '1, 32'hff, 0, 32'h1, 0, 0, 0};
    int          tim[5] = '{5, 15, 20, 784, 196};
    logic [3:0]  cmds[5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h7};
    flash_ecc_status #(.slow_cyc(5), .fast_cyc(3), .mass_cyc(20), .page_cyc(15)) dut (.*);
    flash_read_source src (.*);
    always #5 clk_sys = ~clk_sys;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_sys);
        {reg_read, reg_addr} <= {1'b1, a};
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk_sys);
        reg_read <= 1'b0;
    endtask : rd
    task automatic ev(input bit dat, input logic s, input logic d, input logic irq);
        la = rnd();
        src.read_ev(dat, la, s, d);
        #1;
        `CHK("single_irq", irq, single_irq)
        `CHK("ecc_exception", d, ecc_exception)
    endtask : ev
    task automatic sg(input logic s, input logic d, input logic irq);
        src.sign_ev(s, d, 1'b1);
        #1;
        `CHK("command_irq", irq, command_irq)
        `CHK("ecc_exception", 1'b0, ecc_exception)
    endtask : sg
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    always @(posedge clk_sys) rd_d <= reg_read;
    always @(negedge clk_sys) begin
        if (rd_d && exp_q.size() > 0) begin
            we = exp_q.pop_front();
            wm = msk_q.pop_front();
            `CHK("reg_rdata", we, reg_rdata & wm)
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 12; i++) rd(offs[i], rstv[i], '1);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            wr(offs[3] + 8'(i * 4), v);
            rd(offs[3] + 8'(i * 4), v, '1);
        end
        wr(off_flash_status, rnd());
        rd(off_flash_status, 32'h0, '1);
        wr(off_command_control, 32'h3);
        ev(0, 1, 0, 1);
        rd(off_flash_status, 32'h400, sm);
        repeat (3) ev(0, 1, 0, 1);
        rd(off_flash_status, 32'h60400, sm);
        rd(off_flash_status, 32'h400, sm);
        rd(off_prog_err_addr, la, '1);
        ev(0, 0, 1, 0);
        rd(off_flash_status, 32'h600, sm);
        wr(off_command_control, 32'h2);
        repeat (2) ev(1, 1, 0, 0);
        rd(off_flash_status, 32'h401600, sm);
        ev(1, 0, 1, 0);
        rd(off_data_err_addr, la, '1);
        sg(0, 1, 1);
        rd(off_flash_status, 32'h9e80, sm);
        rd(off_data_err_addr, la, '1);
        sg(1, 0, 1);
        rd(off_flash_status, 32'h11f00, sm);
        sg(0, 0, 0);
        for (int i = 0; i < 5; i++) begin
            wr(off_address_keyhole, i == 4 ? 32'h2_0000 : 32'h0);
            wr(off_command_code, {28'h0, cmds[i]});
            n = 0;
            do begin
                @(negedge clk_sys);
                n++;
            end while (cmd_done !== 1'b1 && n < 2000);
            `CHK("cmd_time", 1'b1, n >= tim[i] && n <= 2 * tim[i] + 4)
            if (n >= 2000) finish_test();
        end
        repeat (3) @(posedge clk_sys);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
